// ==== shared/ueb_defines.svh ====
// register offsets, field positions and reset values for the endpoint bank block
`ifndef UEB_DEFINES_SVH
`define UEB_DEFINES_SVH
// byte offsets on the register bus
`define UEB_DEV_CTRL 8'h00
`define UEB_GEN_FLAGS 8'h04
`define UEB_GEN_EN 8'h08
`define UEB_EP_CFG 8'h0C
`define UEB_EP_FLAGS 8'h10
`define UEB_EP_EN 8'h14
`define UEB_EP_CTRL 8'h18
`define UEB_BYTE_CNT 8'h1C
`define UEB_DATA 8'h20
`define UEB_FRAME 8'h24
// device control bits
`define UEB_B_DETACH 0
`define UEB_B_RMWK 1
`define UEB_B_LSM 2
`define UEB_CTRL_RST 3'h1
// general flag and enable bits, then the frame register crc error bit
`define UEB_B_SOF 2
`define UEB_B_WAKE 4
`define UEB_B_EOR 5
`define UEB_B_UPRS 6
`define UEB_B_FRAME_NUMBER_CRC_ERROR 4
// endpoint flag bits, enables share the low seven
`define UEB_B_RXOUT 0
`define UEB_B_TXIN 1
`define UEB_B_STALL 2
`define UEB_B_NAKOUT 3
`define UEB_B_NAKIN 4
`define UEB_B_UNDER 5
`define UEB_B_OVER 6
`define UEB_B_HANDOFF 7
// endpoint config and control bits
`define UEB_B_DIR 0
`define UEB_B_DBL 1
`define UEB_B_ISO 2
`define UEB_B_KILL 0
`define UEB_B_BANK_ACCESS_ALLOWED 1
`endif

// ==== shared/ueb_pkg.sv ====
// types shared by the endpoint bank block
package ueb_pkg;
   // endpoint direction as held in the config register
   typedef enum logic [0:0] {
      UEB_DIR_OUT = 1'b0,
      UEB_DIR_IN = 1'b1
   } ueb_dir_e;
   // bank select
   typedef logic [0:0] ueb_bank_t;
endpackage

// ==== design/ueb_endpoint_bank.sv ====
// endpoint bank control: cpu/host bank handoff, flags, device control bits
// How it works
// - full out bank sets received and handoff
// - handoff clear releases bank, moves next
// - access bit high while unread bytes remain
// - byte count shown, data port pops bytes
// - second bank fills; full next re-flags
// - free in bank sets free and handoff
// - handoff clear commits in bank, switches
// - in access until full; free re-flags
// - kill discards last written in bank
// - iso in read of empty sets underflow
// - iso out into full banks dropped
// - iso bad crc sets stall, still received
// - long out packet sets overflow, truncates
// - nak answers set nak flags, feed irq
// - sof classed exception on crc error
// - low speed bit moves pull-up to dm
// - wakeup request drives resume, self clears
// - detach bit drops the pull-up
// - upstream resume flag, write one ignored
// - end of resume and wakeup flags
// - flags set regardless of enables
//
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
`include "ueb_defines.svh"
module ueb_endpoint_bank #(
   parameter int BANK_BYTES = 64,
   parameter int RESUME_CYC = 16
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // host out packets from the serial engine
   input wire logic out_valid_i,
   input wire logic [7:0] out_data_i,
   input wire logic out_end_i,
   input wire logic out_crc_bad_i,
   output logic out_nak_o,
   // host in tokens and the transmit stream
   input wire logic in_token_i,
   output logic in_valid_o,
   output logic [7:0] in_data_o,
   output logic in_last_o,
   output logic in_none_o,
   // line and frame events
   input wire logic host_mode_i,
   input wire logic suspend_flag_i,
   input wire logic eor_evt_i,
   input wire logic sof_evt_i,
   input wire logic sof_crc_err_i,
   input wire logic line_active_i,
   // pad controls and interrupt requests
   output logic pullup_dp_o,
   output logic pullup_dm_o,
   output logic resume_drive_o,
   output logic sof_proc_o,
   output logic sof_exc_o,
   output logic endpoint_irq_o,
   output logic usb_irq_o
);
   import ueb_pkg::*;
   localparam int CW = $clog2(BANK_BYTES + 1);
   localparam int IW = $clog2(BANK_BYTES);
   localparam int RW = $clog2(RESUME_CYC + 1);
   localparam logic [CW-1:0] BANK_FULL = CW'(BANK_BYTES);
   localparam logic [RW-1:0] RES_LEN = RW'(RESUME_CYC);
   // whole block state; the bank memory lives here too
   typedef struct packed {
      logic [1:0][BANK_BYTES-1:0][7:0] mem;
      logic [1:0] full; // bank holds a packet
      logic [1:0][CW-1:0] cnt; // bytes per bank
      ueb_bank_t cur; // cpu bank
      ueb_bank_t hb; // host bank
      ueb_bank_t last; // newest committed in bank
      logic [CW-1:0] ptr; // cpu byte pointer
      logic rx_act;
      logic rx_drop;
      logic [CW-1:0] rx_ptr;
      logic tx_act;
      logic [CW-1:0] tx_ptr;
      logic [7:0] ep_f; // endpoint flags
      logic [6:0] ep_en; // endpoint enables
      ueb_dir_e dir;
      logic dbl;
      logic iso;
      logic [2:0] ctrl; // device control
      logic [6:0] gf; // general flags
      logic [6:0] gen; // general enables
      logic frame_number_crc_error;
      logic [RW-1:0] res_cnt;
      logic res_act;
      logic [2:0] sync;
      logic act_prev;
      logic ack;
      logic [7:0] rdata;
      logic in_valid;
      logic [7:0] in_data;
      logic in_last;
      logic in_none;
      logic out_nak;
      logic sof_p;
      logic sof_x;
   } ueb_state_s;
   ueb_state_s st_r;
   ueb_state_s st_nxt;
   // bus strobes: req opens the cycle, acc is the ack edge
   logic req;
   logic acc;
   logic wr;
   logic bank_access_allowed;
   logic act_f;
   logic first;
   logic drop_now;
   logic [CW-1:0] rx_idx;
   assign req = wb_cyc_i & wb_stb_i & ~st_r.ack;
   assign acc = wb_cyc_i & wb_stb_i & st_r.ack;
   assign wr = acc & wb_we_i & wb_sel_i[0];
   // access bit follows the cpu bank in either direction
   always_comb begin
      if (st_r.dir == UEB_DIR_OUT) begin
         bank_access_allowed = st_r.ep_f[`UEB_B_HANDOFF] & (st_r.ptr < st_r.cnt[st_r.cur]);
      end else begin
         bank_access_allowed = st_r.ep_f[`UEB_B_HANDOFF] & (st_r.ptr < BANK_FULL);
      end
   end
   // line activity only counts once the last two stages agree
   assign act_f = st_r.sync[2] & st_r.sync[1];
   assign first = ~st_r.rx_act;
   // a packet that opens into a full bank is thrown away whole
   assign drop_now = first ? st_r.full[st_r.hb] : st_r.rx_drop;
   assign rx_idx = first ? '0 : st_r.rx_ptr;
   // next state of everything
   always_comb begin
      st_nxt = st_r;
      st_nxt.out_nak = 1'b0;
      st_nxt.in_valid = 1'b0;
      st_nxt.in_last = 1'b0;
      st_nxt.in_none = 1'b0;
      st_nxt.sof_p = 1'b0;
      st_nxt.sof_x = 1'b0;
      st_nxt.sync = {st_r.sync[1:0], line_active_i};
      st_nxt.act_prev = act_f;
      st_nxt.ack = req;
      // read data is caught as the request opens, ready with ack
      if (req) begin
         case (wb_adr_i)
            `UEB_DEV_CTRL: st_nxt.rdata = {5'h00, st_r.ctrl};
            `UEB_GEN_FLAGS: st_nxt.rdata = {1'b0, st_r.gf};
            `UEB_GEN_EN: st_nxt.rdata = {1'b0, st_r.gen};
            `UEB_EP_CFG: st_nxt.rdata = {5'h00, st_r.iso, st_r.dbl, st_r.dir};
            `UEB_EP_FLAGS: st_nxt.rdata = st_r.ep_f;
            `UEB_EP_EN: st_nxt.rdata = {1'b0, st_r.ep_en};
            `UEB_EP_CTRL: st_nxt.rdata = {6'h00, bank_access_allowed, 1'b0};
            `UEB_BYTE_CNT: st_nxt.rdata = 8'(st_r.cnt[st_r.cur]);
            `UEB_DATA: begin
               if (st_r.dir == UEB_DIR_OUT && bank_access_allowed) begin
                  st_nxt.rdata = st_r.mem[st_r.cur][st_r.ptr[IW-1:0]];
               end else begin
                  st_nxt.rdata = 8'h00;
               end
            end
            `UEB_FRAME: st_nxt.rdata = {3'h0, st_r.frame_number_crc_error, 4'h0};
            default: st_nxt.rdata = 8'h00; // unmapped reads zero
         endcase
      end
      // register writes; flags clear by writing zero, ones are ignored
      if (wr) begin
         case (wb_adr_i)
            `UEB_DEV_CTRL: begin
               st_nxt.ctrl[`UEB_B_LSM] = wb_dat_i[`UEB_B_LSM];
               st_nxt.ctrl[`UEB_B_DETACH] = wb_dat_i[`UEB_B_DETACH];
               // a zero write leaves a running request alone
               if (wb_dat_i[`UEB_B_RMWK] && suspend_flag_i && !st_r.res_act) begin
                  st_nxt.ctrl[`UEB_B_RMWK] = 1'b1;
                  st_nxt.res_act = 1'b1;
                  st_nxt.res_cnt = RES_LEN;
               end
            end
            `UEB_GEN_FLAGS: st_nxt.gf = st_r.gf & wb_dat_i[6:0];
            `UEB_GEN_EN: st_nxt.gen = wb_dat_i[6:0];
            `UEB_EP_CFG: begin
               st_nxt.dir = ueb_dir_e'(wb_dat_i[`UEB_B_DIR]);
               st_nxt.dbl = wb_dat_i[`UEB_B_DBL];
               st_nxt.iso = wb_dat_i[`UEB_B_ISO];
            end
            `UEB_EP_FLAGS: begin
               st_nxt.ep_f = st_r.ep_f & wb_dat_i[7:0];
               // handing the bank over: release or commit it, then step on
               if (st_r.ep_f[`UEB_B_HANDOFF] && !wb_dat_i[`UEB_B_HANDOFF]) begin
                  if (st_r.dir == UEB_DIR_OUT) begin
                     st_nxt.full[st_r.cur] = 1'b0;
                  end else begin
                     st_nxt.full[st_r.cur] = 1'b1;
                     st_nxt.cnt[st_r.cur] = st_r.ptr;
                     st_nxt.last = st_r.cur;
                  end
                  st_nxt.cur = st_r.dbl ? ~st_r.cur : 1'b0;
                  st_nxt.ptr = '0;
               end
            end
            `UEB_EP_EN: st_nxt.ep_en = wb_dat_i[6:0];
            `UEB_EP_CTRL: begin
               // cannot pull back a bank already on the wire
               if (wb_dat_i[`UEB_B_KILL] && st_r.dir == UEB_DIR_IN &&
                   st_r.full[st_r.last] && !(st_r.tx_act && st_r.hb == st_r.last)) begin
                  st_nxt.full[st_r.last] = 1'b0;
               end
            end
            `UEB_DATA: begin
               if (st_r.dir == UEB_DIR_IN && bank_access_allowed) begin
                  st_nxt.mem[st_r.cur][st_r.ptr[IW-1:0]] = wb_dat_i[7:0];
                  st_nxt.ptr = st_r.ptr + 1'b1;
               end
            end
            default: ; // unmapped writes dropped
         endcase
      end
      // reading the data port pops one byte
      if (acc && !wb_we_i && wb_adr_i == `UEB_DATA && st_r.dir == UEB_DIR_OUT && bank_access_allowed) begin
         st_nxt.ptr = st_r.ptr + 1'b1;
      end
      // host out bytes land in the host bank while the cpu reads its own
      if (st_r.dir == UEB_DIR_OUT && (out_valid_i || out_end_i)) begin
         st_nxt.rx_act = ~out_end_i;
         st_nxt.rx_drop = drop_now;
         st_nxt.rx_ptr = rx_idx;
         if (first && drop_now) begin
            if (st_r.iso) begin
               st_nxt.ep_f[`UEB_B_UNDER] = 1'b1;
            end else begin
               st_nxt.ep_f[`UEB_B_NAKOUT] = 1'b1;
               st_nxt.out_nak = 1'b1;
            end
         end
         if (!drop_now && out_valid_i) begin
            // bytes past the bank end are counted as overflow, not stored
            if (rx_idx < BANK_FULL) begin
               st_nxt.mem[st_r.hb][rx_idx[IW-1:0]] = out_data_i;
               st_nxt.rx_ptr = rx_idx + 1'b1;
            end else begin
               st_nxt.ep_f[`UEB_B_OVER] = 1'b1;
            end
         end
         if (!drop_now && out_end_i) begin
            st_nxt.full[st_r.hb] = 1'b1;
            st_nxt.cnt[st_r.hb] = (out_valid_i && rx_idx < BANK_FULL) ? rx_idx + 1'b1 : rx_idx;
            st_nxt.hb = st_r.dbl ? ~st_r.hb : 1'b0;
            if (st_r.iso && out_crc_bad_i) begin
               st_nxt.ep_f[`UEB_B_STALL] = 1'b1;
            end
         end
      end
      // in token: stream the oldest committed bank or answer with nothing
      if (st_r.dir == UEB_DIR_IN && in_token_i && !st_r.tx_act) begin
         if (st_r.full[st_r.hb]) begin
            st_nxt.tx_act = 1'b1;
            st_nxt.tx_ptr = '0;
         end else begin
            st_nxt.in_none = 1'b1;
            if (st_r.iso) begin
               st_nxt.ep_f[`UEB_B_UNDER] = 1'b1;
            end else begin
               st_nxt.ep_f[`UEB_B_NAKIN] = 1'b1;
            end
         end
      end
      // one byte a cycle; a zero-length bank gives a lone last strobe
      if (st_r.tx_act) begin
         st_nxt.in_valid = st_r.tx_ptr < st_r.cnt[st_r.hb];
         st_nxt.in_data = st_r.mem[st_r.hb][st_r.tx_ptr[IW-1:0]];
         st_nxt.tx_ptr = st_r.tx_ptr + 1'b1;
         if (st_r.tx_ptr + 1'b1 >= st_r.cnt[st_r.hb]) begin
            st_nxt.in_last = 1'b1;
            st_nxt.tx_act = 1'b0;
            st_nxt.full[st_r.hb] = 1'b0;
            st_nxt.hb = st_r.dbl ? ~st_r.hb : 1'b0;
         end
      end
      // present the cpu bank; a ready next bank re-flags at once
      if (!st_r.ep_f[`UEB_B_HANDOFF]) begin
         if (st_r.dir == UEB_DIR_OUT && st_r.full[st_r.cur]) begin
            st_nxt.ep_f[`UEB_B_RXOUT] = 1'b1;
            st_nxt.ep_f[`UEB_B_HANDOFF] = 1'b1;
            st_nxt.ptr = '0;
         end
         if (st_r.dir == UEB_DIR_IN && !st_r.full[st_r.cur]) begin
            st_nxt.ep_f[`UEB_B_TXIN] = 1'b1;
            st_nxt.ep_f[`UEB_B_HANDOFF] = 1'b1;
            st_nxt.ptr = '0;
         end
      end
      // upstream resume timing; flag held set while it runs
      if (st_r.res_act) begin
         st_nxt.gf[`UEB_B_UPRS] = 1'b1;
         st_nxt.res_cnt = st_r.res_cnt - 1'b1;
         if (st_r.res_cnt <= RW'(1)) begin
            st_nxt.res_act = 1'b0;
            st_nxt.ctrl[`UEB_B_RMWK] = 1'b0;
         end
      end
      // line events set flags whatever the enables say
      if (eor_evt_i) begin
         st_nxt.gf[`UEB_B_EOR] = 1'b1;
      end
      // our own resume on the line is not a wakeup
      if (act_f && !st_r.act_prev && !st_r.res_act) begin
         st_nxt.gf[`UEB_B_WAKE] = 1'b1;
      end
      if (sof_evt_i) begin
         st_nxt.gf[`UEB_B_SOF] = 1'b1;
         st_nxt.frame_number_crc_error = sof_crc_err_i;
         st_nxt.sof_x = sof_crc_err_i;
         st_nxt.sof_p = ~sof_crc_err_i;
      end
   end
   // one register for the whole state
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st_r <= '0;
         st_r.ctrl <= `UEB_CTRL_RST;
      end else begin
         st_r <= st_nxt;
      end
   end
   // outputs
   assign wb_ack_o = st_r.ack;
   assign wb_dat_o = {24'h000000, st_r.rdata};
   assign out_nak_o = st_r.out_nak;
   assign in_valid_o = st_r.in_valid;
   assign in_data_o = st_r.in_data;
   assign in_last_o = st_r.in_last;
   assign in_none_o = st_r.in_none;
   assign sof_proc_o = st_r.sof_p;
   assign sof_exc_o = st_r.sof_x;
   assign resume_drive_o = st_r.res_act;
   // pull-up only in device mode; the speed bit picks the line
   assign pullup_dp_o = ~host_mode_i & ~st_r.ctrl[`UEB_B_DETACH] & ~st_r.ctrl[`UEB_B_LSM];
   assign pullup_dm_o = ~host_mode_i & ~st_r.ctrl[`UEB_B_DETACH] & st_r.ctrl[`UEB_B_LSM];
   assign endpoint_irq_o = |(st_r.ep_f[6:0] & st_r.ep_en);
   assign usb_irq_o = |(st_r.gf & st_r.gen);
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);
   a_out_pair_set: assert property ($rose(st_r.ep_f[`UEB_B_RXOUT]) && st_r.dir == UEB_DIR_OUT
      |-> st_r.ep_f[`UEB_B_HANDOFF] && st_r.full[st_r.cur]) else $error("out flags apart");
   a_in_pair_set: assert property ($rose(st_r.ep_f[`UEB_B_TXIN]) && st_r.dir == UEB_DIR_IN
      |-> st_r.ep_f[`UEB_B_HANDOFF] && !st_r.full[st_r.cur]) else $error("in flags apart");
   a_bank_step: assert property (wr && wb_adr_i == `UEB_EP_FLAGS && st_r.ep_f[`UEB_B_HANDOFF]
      && !wb_dat_i[`UEB_B_HANDOFF] |=> st_r.ptr == '0 && st_r.cur == ($past(st_r.dbl) ?
      ~$past(st_r.cur) : 1'b0)) else $error("bank did not step");
   a_bank_access_allowed_empty: assert property (st_r.dir == UEB_DIR_OUT && bank_access_allowed
      |-> st_r.full[st_r.cur]) else $error("access with empty bank");
   a_under_iso: assert property ($rose(in_none_o) && st_r.iso |-> st_r.ep_f[`UEB_B_UNDER])
      else $error("no underflow");
   a_nak_in: assert property (in_none_o && !st_r.iso |-> st_r.ep_f[`UEB_B_NAKIN])
      else $error("nak in not flagged");
   a_ovf_flag: assert property (st_r.dir == UEB_DIR_OUT && out_valid_i && !drop_now
      && rx_idx == BANK_FULL |=> st_r.ep_f[`UEB_B_OVER]) else $error("overflow lost");
   a_resume_len: assert property ($rose(st_r.res_act) |-> st_r.ctrl[`UEB_B_RMWK]
      ##RESUME_CYC !st_r.res_act && !st_r.ctrl[`UEB_B_RMWK]) else $error("resume length");
   a_pullup_side: assert property (pullup_dp_o |-> !pullup_dm_o && !st_r.ctrl[`UEB_B_DETACH])
      else $error("pull-up wrong");
   a_sof_class: assert property (sof_evt_i |=> sof_exc_o == $past(sof_crc_err_i)
      && sof_proc_o == !$past(sof_crc_err_i)) else $error("sof class wrong");
endmodule

// ==== tb/ueb_usb_host.sv ====
// bus-side host model: sends out packets, issues in tokens, gathers replies
`timescale 1ns/100ps
module ueb_usb_host (
   // clock
   input wire logic clk_i,
   // out packet lines towards the block
   output logic out_valid_o,
   output logic [7:0] out_data_o,
   output logic out_end_o,
   output logic out_crc_bad_o,
   input wire logic out_nak_i,
   // in token and transmit stream
   output logic in_token_o,
   input wire logic in_valid_i,
   input wire logic [7:0] in_data_i,
   input wire logic in_last_i,
   input wire logic in_none_i
);
   logic [7:0] rx_q[$]; // bytes received from in packets
   int nak_cnt = 0; // out packets refused
   int none_cnt = 0; // tokens answered with no data
   initial begin
      out_valid_o = 1'b0;
      out_data_o = 8'hA5;
      out_end_o = 1'b0;
      out_crc_bad_o = 1'b0;
      in_token_o = 1'b0;
   end
   // gather the block's answers at each edge
   always @(posedge clk_i) begin
      if (in_valid_i) rx_q.push_back(in_data_i);
      if (in_none_i) none_cnt++;
      if (out_nak_i) nak_cnt++;
   end
   // out packet of n counting bytes; crc status goes with the closing byte
   task automatic send_out(input int n, input logic [7:0] first, input logic bad);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_i);
         out_valid_o <= 1'b1;
         out_data_o <= first + 8'(i);
         out_end_o <= (i == n - 1);
         out_crc_bad_o <= bad & (i == n - 1);
      end
      @(posedge clk_i);
      out_valid_o <= 1'b0;
      out_end_o <= 1'b0;
      out_crc_bad_o <= 1'b0;
      // released line must not keep showing the last byte
      out_data_o <= ~out_data_o;
      repeat (6) @(posedge clk_i);
   endtask
   // one in token, then wait for the reply to finish
   task automatic send_token();
      logic seen;
      @(posedge clk_i);
      in_token_o <= 1'b1;
      @(posedge clk_i);
      in_token_o <= 1'b0;
      seen = 1'b0;
      for (int t = 0; t < 200 && !seen; t++) begin
         @(posedge clk_i);
         seen = in_last_i | in_none_i;
      end
      repeat (3) @(posedge clk_i);
   endtask
endmodule

// ==== tb/test_ueb_endpoint_bank.sv ====
// self-checking bench for the endpoint bank block
`timescale 1ns/100ps
`include "ueb_defines.svh"
module test_ueb_endpoint_bank;
   import ueb_pkg::*;
   localparam int BB = 8; // short bank so overflow is cheap to reach
   localparam int RC = 40; // resume long enough to read back while driving
   logic clk_i = 1'b0, srst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic out_valid_i, out_end_i, out_crc_bad_i, out_nak_o, in_token_i;
   logic [7:0] out_data_i, in_data_o;
   logic in_valid_o, in_last_o, in_none_o;
   logic host_mode_i = 1'b0, suspend_flag_i = 1'b0, eor_evt_i = 1'b0;
   logic sof_evt_i = 1'b0, sof_crc_err_i = 1'b0, line_active_i = 1'b0;
   logic pullup_dp_o, pullup_dm_o, resume_drive_o, sof_proc_o, sof_exc_o;
   logic endpoint_irq_o, usb_irq_o;
   int fails = 0, comparisons = 0, cycles = 0;
   ueb_endpoint_bank #(.BANK_BYTES(BB), .RESUME_CYC(RC)) i_ueb_endpoint_bank (
      .clk_i(clk_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .out_valid_i(out_valid_i),
      .out_data_i(out_data_i), .out_end_i(out_end_i), .out_crc_bad_i(out_crc_bad_i),
      .out_nak_o(out_nak_o), .in_token_i(in_token_i), .in_valid_o(in_valid_o),
      .in_data_o(in_data_o), .in_last_o(in_last_o), .in_none_o(in_none_o),
      .host_mode_i(host_mode_i), .suspend_flag_i(suspend_flag_i), .eor_evt_i(eor_evt_i),
      .sof_evt_i(sof_evt_i), .sof_crc_err_i(sof_crc_err_i), .line_active_i(line_active_i),
      .pullup_dp_o(pullup_dp_o), .pullup_dm_o(pullup_dm_o), .resume_drive_o(resume_drive_o),
      .sof_proc_o(sof_proc_o), .sof_exc_o(sof_exc_o), .endpoint_irq_o(endpoint_irq_o),
      .usb_irq_o(usb_irq_o));
   ueb_usb_host i_ueb_usb_host (
      .clk_i(clk_i), .out_valid_o(out_valid_i), .out_data_o(out_data_i),
      .out_end_o(out_end_i), .out_crc_bad_o(out_crc_bad_i), .out_nak_i(out_nak_o),
      .in_token_o(in_token_i), .in_valid_i(in_valid_o), .in_data_i(in_data_o),
      .in_last_i(in_last_o), .in_none_i(in_none_o));
   // 200 MHz clock
   always #2.5 clk_i = ~clk_i;
   // hang guard, well above the few hundred cycles the run needs
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // word compare
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // single output bit compare
   task automatic chk_b(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic done(input string name);
      $display("test %s finished", name);
   endtask
   // classic cycle: hold the request until ack is sampled high
   task automatic xfer(input logic we, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] rd);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= {24'h000000, d};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] r;
      xfer(1'b0, a, 8'h00, r);
      chk(r, {24'h000000, e});
   endtask
   // drain n bytes through the data port, expecting a counting pattern
   task automatic rd_bytes(input int n, input logic [7:0] first);
      for (int i = 0; i < n; i++) rc(`UEB_DATA, first + 8'(i));
   endtask
   task automatic wr_bytes(input int n, input logic [7:0] first);
      for (int i = 0; i < n; i++) wr(`UEB_DATA, first + 8'(i));
   endtask
   // received flag is cleared before the handoff bit
   task automatic release_bank();
      wr(`UEB_EP_FLAGS, 8'h80);
      wr(`UEB_EP_FLAGS, 8'h00);
   endtask
   task automatic sof(input logic err);
      @(posedge clk_i);
      sof_evt_i <= 1'b1;
      sof_crc_err_i <= err;
      @(posedge clk_i);
      sof_evt_i <= 1'b0;
      sof_crc_err_i <= 1'b0;
      @(posedge clk_i);
      chk_b(sof_exc_o, err);
      chk_b(sof_proc_o, ~err);
   endtask
   initial begin
      tick(6);
      srst_i <= 1'b0;
      chk_b(pullup_dp_o | pullup_dm_o, 1'b0);
      rc(`UEB_DEV_CTRL, 8'h01);
      rc(`UEB_EP_FLAGS, 8'h00);
      rc(8'h30, 8'h00);
      done("reset");
      wr(`UEB_DEV_CTRL, 8'h00);
      tick(1);
      chk_b(pullup_dp_o, 1'b1);
      wr(`UEB_DEV_CTRL, 8'h04);
      tick(1);
      chk_b(pullup_dm_o & ~pullup_dp_o, 1'b1);
      host_mode_i <= 1'b1;
      tick(2);
      chk_b(pullup_dm_o, 1'b0);
      host_mode_i <= 1'b0;
      wr(`UEB_DEV_CTRL, 8'h05);
      tick(1);
      chk_b(pullup_dm_o, 1'b0);
      done("pull-up");
      wr(`UEB_EP_EN, 8'h01);
      i_ueb_usb_host.send_out(3, 8'h10, 1'b0);
      rc(`UEB_EP_FLAGS, 8'h81);
      chk_b(endpoint_irq_o, 1'b1);
      rc(`UEB_BYTE_CNT, 8'h03);
      rc(`UEB_EP_CTRL, 8'h02);
      rd_bytes(3, 8'h10);
      rc(`UEB_EP_CTRL, 8'h00);
      wr(`UEB_EP_FLAGS, 8'h80);
      tick(1);
      chk_b(endpoint_irq_o, 1'b0);
      wr(`UEB_EP_EN, 8'h08);
      i_ueb_usb_host.send_out(2, 8'h70, 1'b0);
      chk(32'(i_ueb_usb_host.nak_cnt), 1);
      rc(`UEB_EP_FLAGS, 8'h88);
      chk_b(endpoint_irq_o, 1'b1);
      release_bank();
      rc(`UEB_EP_FLAGS, 8'h00);
      i_ueb_usb_host.send_out(BB + 2, 8'h20, 1'b0);
      rc(`UEB_EP_FLAGS, 8'hC1);
      rc(`UEB_BYTE_CNT, 8'(BB));
      rd_bytes(BB, 8'h20);
      release_bank();
      done("out single bank");
      wr(`UEB_EP_CFG, 8'h02);
      i_ueb_usb_host.send_out(2, 8'h30, 1'b0);
      i_ueb_usb_host.send_out(3, 8'h40, 1'b0);
      chk(32'(i_ueb_usb_host.nak_cnt), 1);
      rd_bytes(2, 8'h30);
      release_bank();
      rc(`UEB_EP_FLAGS, 8'h81);
      rc(`UEB_BYTE_CNT, 8'h03);
      rd_bytes(3, 8'h40);
      release_bank();
      rc(`UEB_EP_FLAGS, 8'h00);
      done("out double bank");
      wr(`UEB_EP_CFG, 8'h04);
      i_ueb_usb_host.send_out(2, 8'h60, 1'b1);
      rc(`UEB_EP_FLAGS, 8'h85);
      i_ueb_usb_host.send_out(2, 8'h68, 1'b0);
      rc(`UEB_EP_FLAGS, 8'hA5);
      chk(32'(i_ueb_usb_host.nak_cnt), 1);
      rd_bytes(2, 8'h60);
      release_bank();
      done("iso out");
      wr(`UEB_EP_CFG, 8'h01);
      wr(`UEB_EP_EN, 8'h22);
      rc(`UEB_EP_FLAGS, 8'h82);
      chk_b(endpoint_irq_o, 1'b1);
      rc(`UEB_EP_CTRL, 8'h02);
      wr(`UEB_EP_FLAGS, 8'h80);
      wr_bytes(3, 8'h50);
      wr(`UEB_EP_FLAGS, 8'h00);
      rc(`UEB_EP_FLAGS, 8'h00);
      i_ueb_usb_host.send_token();
      chk(32'(i_ueb_usb_host.rx_q.size()), 3);
      for (int i = 0; i < 3; i++) chk({24'h0, i_ueb_usb_host.rx_q[i]}, 32'h50 + i);
      rc(`UEB_EP_FLAGS, 8'h82);
      wr(`UEB_EP_FLAGS, 8'h80);
      wr_bytes(BB, 8'h58);
      rc(`UEB_EP_CTRL, 8'h00);
      wr(`UEB_EP_FLAGS, 8'h00);
      wr(`UEB_EP_CTRL, 8'h01);
      rc(`UEB_EP_FLAGS, 8'h82);
      i_ueb_usb_host.send_token();
      chk(32'(i_ueb_usb_host.none_cnt), 1);
      wr(`UEB_EP_CFG, 8'h05);
      i_ueb_usb_host.send_token();
      rc(`UEB_EP_FLAGS, 8'hB2);
      chk(32'(i_ueb_usb_host.none_cnt), 2);
      wr(`UEB_EP_CFG, 8'h03);
      wr(`UEB_EP_FLAGS, 8'h80);
      wr_bytes(1, 8'h90);
      wr(`UEB_EP_FLAGS, 8'h00);
      rc(`UEB_EP_FLAGS, 8'h82);
      done("in banks");
      suspend_flag_i <= 1'b1;
      wr(`UEB_DEV_CTRL, 8'h02);
      tick(1);
      chk_b(resume_drive_o, 1'b1);
      wr(`UEB_DEV_CTRL, 8'h00);
      rc(`UEB_DEV_CTRL, 8'h02);
      wr(`UEB_GEN_FLAGS, 8'h40);
      rc(`UEB_GEN_FLAGS, 8'h40);
      chk_b(usb_irq_o, 1'b0);
      suspend_flag_i <= 1'b0;
      tick(RC + 4);
      chk_b(resume_drive_o, 1'b0);
      rc(`UEB_DEV_CTRL, 8'h00);
      wr(`UEB_GEN_EN, 8'h60);
      tick(1);
      chk_b(usb_irq_o, 1'b1);
      wr(`UEB_GEN_FLAGS, 8'h00);
      eor_evt_i <= 1'b1;
      tick(1);
      eor_evt_i <= 1'b0;
      rc(`UEB_GEN_FLAGS, 8'h20);
      chk_b(usb_irq_o, 1'b1);
      wr(`UEB_GEN_FLAGS, 8'h00);
      line_active_i <= 1'b1;
      tick(8);
      rc(`UEB_GEN_FLAGS, 8'h10);
      chk_b(usb_irq_o, 1'b0);
      wr(`UEB_GEN_FLAGS, 8'hFF);
      rc(`UEB_GEN_FLAGS, 8'h10);
      sof(1'b1);
      rc(`UEB_FRAME, 8'h10);
      sof(1'b0);
      done("general");
      stop_test();
   end
endmodule
